// [src/charger_regs_pkg.sv]
// constants, field layout and reset values for the charger shadow registers
package charger_regs_pkg;
   // clock and timing
   localparam int CLK_HZ          = 25_000_000;
   localparam int WDT_REFRESH_S   = 15;
   localparam int WDT_REFRESH_CYC = WDT_REFRESH_S * CLK_HZ; // longest: floor
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_VOLT    = 8'h79;
   localparam logic [7:0] IDX_TERM    = 8'h7a;
   localparam logic [7:0] IDX_IRTH    = 8'h7b;
   localparam logic [7:0] IDX_MISC    = 8'h7c;
   localparam logic [7:0] IDX_FCC     = 8'h70;
   localparam logic [7:0] IDX_IRQ_ST  = 8'h71;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h72;
   localparam logic [7:0] IDX_IRQ_EN  = 8'h73;
   // software write masks
   localparam logic [7:0] WMASK_VOLT = 8'h02;
   localparam logic [7:0] WMASK_TERM = 8'h4e;
   localparam logic [7:0] WMASK_IRTH = 8'hff;
   localparam logic [7:0] WMASK_MISC = 8'hc3;
   // gauge-driven bits
   localparam logic [7:0] GMASK_VOLT = 8'hfc;
   localparam logic [7:0] GMASK_MISC = 8'h20;
   // fixed bits and their values
   localparam logic [7:0] FMASK_VOLT = 8'h01;
   localparam logic [7:0] FIX_VOLT   = 8'h01;
   localparam logic [7:0] FMASK_TERM = 8'hb1;
   localparam logic [7:0] FIX_TERM   = 8'h10;
   localparam logic [7:0] FMASK_MISC = 8'h1c;
   localparam logic [7:0] FIX_MISC   = 8'h08;
   // reset values (configuration storage defaults)
   localparam logic [7:0] RST_VOLT = 8'h01;
   localparam logic [7:0] RST_TERM = 8'h1a;
   localparam logic [7:0] RST_IRTH = 8'h03;
   localparam logic [7:0] RST_MISC = 8'h4b;
   localparam logic [7:0] RST_FCC  = 8'h5f;
   // field positions
   localparam int VCODE_LSB    = 2;
   localparam int BATLOW_BIT   = 1;
   localparam int TIMER_LSB    = 1;
   localparam int IRCOMP_LSB   = 5;
   localparam int CLAMP_LSB    = 2;
   localparam int THERMAL_REG_THRESHOLD_LSB     = 0;
   localparam int BATOFF_BIT   = 5;
   localparam int MASK_CHG_BIT = 1;
   localparam int MASK_BAT_BIT = 0;
   // scaling
   localparam logic [12:0] VOLT_OFFSET_MV = 13'h0db0;
   localparam logic [11:0] PRE_LOW_MV     = 12'haf0;
   localparam logic [11:0] PRE_HIGH_MV    = 12'hbb8;
   localparam logic [6:0]  IR_STEP_MOHM   = 7'h0a;
   localparam logic [6:0]  CLAMP_STEP_MV  = 7'h10;
   localparam logic [6:0]  THERMAL_REG_THRESHOLD_BASE_C    = 7'h3c;
   localparam logic [6:0]  THERMAL_REG_THRESHOLD_STEP_C    = 7'h14;
   localparam logic [15:0] TERM_MA        = 16'h0100;
   localparam logic [4:0]  HRS_0 = 5'h05;
   localparam logic [4:0]  HRS_1 = 5'h08;
   localparam logic [4:0]  HRS_2 = 5'h0c;
   localparam logic [4:0]  HRS_3 = 5'h14;
   // interrupt status layout
   localparam int IRQ_W     = 3;
   localparam int IRQ_BAT   = 0;
   localparam int IRQ_CHG   = 1;
   localparam int IRQ_RECHG = 2;
endpackage

// [src/charger_shadow_control_regs.sv]
// charger shadow control registers with ahb-lite slave and fault interrupts
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module charger_shadow_control_regs
   import charger_regs_pkg::*;
#(
   parameter int WDT_CYC = WDT_REFRESH_CYC   // refresh interval in cycles
)
(
   input  wire logic        hclk,              // bus clock
   input  wire logic        hresetn,           // async reset, low
   input  wire logic        hsel,              // slave select
   input  wire logic [31:0] haddr,             // byte address
   input  wire logic [1:0]  htrans,            // transfer type
   input  wire logic        hwrite,            // write flag
   input  wire logic [2:0]  hsize,             // word only
   input  wire logic [31:0] hwdata,            // write data
   input  wire logic        hready,            // bus ready
   output logic             hreadyout,         // always ready
   output logic             hresp,             // always okay
   output logic [31:0]      hrdata,            // read data
   input  wire logic [5:0]  gauge_vcode,       // voltage code from gauge
   input  wire logic        gauge_batfet_off,  // battery switch request
   input  wire logic [1:0]  chg_fault_pin,     // charger fault code pins
   input  wire logic        battery_fault_flag_pin,     // charger battery fault pin
   input  wire logic        charging,          // gauge charging state
   input  wire logic        charge_full,       // gauge full flag
   input  wire logic [7:0]  soc_pct,           // state of charge
   input  wire logic [15:0] avg_current_ma,    // coulomb counter current
   output logic [7:0]       volt_ctrl,         // charge_voltage_ctrl
   output logic [7:0]       term_ctrl,         // term_timer_ctrl
   output logic [7:0]       irth_ctrl,         // ir_thermal_ctrl
   output logic [7:0]       misc_ctrl,         // misc_operation_ctrl
   output logic             chg_update,        // pulse: a byte changed
   output logic [12:0]      prog_voltage_mv,   // programmed voltage
   output logic [11:0]      pre_exit_mv,       // precharge exit threshold
   output logic [4:0]       fast_timer_hrs,    // fast charge timer
   output logic [6:0]       ir_comp_mohm,      // ir compensation
   output logic [6:0]       ir_clamp_mv,       // ir clamp
   output logic [6:0]       thermal_reg_threshold_degc,         // thermal threshold
   output logic             wdt_refresh,       // pulse: refresh watchdog
   output logic             recharge_req,      // pulse: start recharge
   output logic             charge_done,       // termination detected
   output logic             irq                // level interrupt
);
   localparam int CW = $clog2(WDT_CYC + 1);

   logic        take;
   logic        addr_ok;
   logic        wr_pend_r, wr_pend_nxt;
   logic [9:0]  wr_addr_r, wr_addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic        we_volt, we_term, we_irth, we_misc;
   logic        we_fcc, we_clr, we_en;
   logic [7:0]  wbyte;
   logic [7:0]  volt_r, volt_nxt, term_r, term_nxt;
   logic [7:0]  irth_r, irth_nxt, misc_r, misc_nxt;
   logic [7:0]  fcc_r, fcc_nxt;
   logic [IRQ_W-1:0] st_r, st_nxt, en_r, en_nxt, ev;
   logic        irq_r, irq_nxt;

   // merge a write under its mask, then overlay gauge and fixed bits
   function automatic logic [7:0] merge(input logic [7:0] cur,
      input logic [7:0] wd, input logic [7:0] wm, input logic [7:0] gm,
      input logic [7:0] gv, input logic [7:0] fm, input logic [7:0] fv);
      logic [7:0] t;
      t = (cur & ~wm) | (wd & wm);
      return (t & ~gm & ~fm) | (gv & gm) | (fv & fm);
   endfunction

   // address phase accept; zero wait states so hready is never pulled low
   assign take    = hsel & htrans[1] & hready;
   assign addr_ok = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);
   assign wbyte   = hwdata[7:0];

   // data-phase write decode
   assign we_volt = wr_pend_r & (wr_addr_r == {IDX_VOLT, 2'b00});
   assign we_term = wr_pend_r & (wr_addr_r == {IDX_TERM, 2'b00});
   assign we_irth = wr_pend_r & (wr_addr_r == {IDX_IRTH, 2'b00});
   assign we_misc = wr_pend_r & (wr_addr_r == {IDX_MISC, 2'b00});
   assign we_fcc  = wr_pend_r & (wr_addr_r == {IDX_FCC, 2'b00});
   assign we_clr  = wr_pend_r & (wr_addr_r == {IDX_IRQ_CLR, 2'b00});
   assign we_en   = wr_pend_r & (wr_addr_r == {IDX_IRQ_EN, 2'b00});

   // register next values; read-only bits are masked out of every write
   always_comb
   begin
      volt_nxt = merge(volt_r, wbyte, we_volt ? WMASK_VOLT : '0,
                       GMASK_VOLT, {gauge_vcode, 2'b00},
                       FMASK_VOLT, FIX_VOLT);
      term_nxt = merge(term_r, wbyte, we_term ? WMASK_TERM : '0,
                       '0, '0, FMASK_TERM, FIX_TERM);
      irth_nxt = merge(irth_r, wbyte, we_irth ? WMASK_IRTH : '0,
                       '0, '0, '0, '0);
      misc_nxt = merge(misc_r, wbyte, we_misc ? WMASK_MISC : '0,
                       GMASK_MISC, {2'b00, gauge_batfet_off, 5'h00},
                       FMASK_MISC, FIX_MISC);
      fcc_nxt  = we_fcc ? wbyte : fcc_r;
      en_nxt   = we_en ? hwdata[IRQ_W-1:0] : en_r;
      // a set in the clearing cycle survives
      st_nxt   = (st_r & ~(we_clr ? hwdata[IRQ_W-1:0] : '0)) | ev;
      irq_nxt  = |(st_nxt & en_nxt);
   end

   // read mux looks at next values so a read right after a write sees it
   always_comb
   begin
      wr_pend_nxt = take & hwrite & addr_ok;
      wr_addr_nxt = take ? haddr[9:0] : wr_addr_r;
      hrdata_nxt  = hrdata_r;
      if (take & ~hwrite)
      begin
         hrdata_nxt = 32'h0;
         if (addr_ok)
         begin
            case (haddr[9:2])
               IDX_VOLT:   hrdata_nxt[7:0] = volt_nxt;
               IDX_TERM:   hrdata_nxt[7:0] = term_nxt;
               IDX_IRTH:   hrdata_nxt[7:0] = irth_nxt;
               IDX_MISC:   hrdata_nxt[7:0] = misc_nxt;
               IDX_FCC:    hrdata_nxt[7:0] = fcc_nxt;
               IDX_IRQ_ST: hrdata_nxt[IRQ_W-1:0] = st_nxt;
               IDX_IRQ_EN: hrdata_nxt[IRQ_W-1:0] = en_nxt;
               default:    hrdata_nxt = 32'h0;
            endcase
         end
      end
   end

   // bus and register state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 10'h000;
         hrdata_r  <= 32'h0;
         volt_r    <= RST_VOLT;
         term_r    <= RST_TERM;
         irth_r    <= RST_IRTH;
         misc_r    <= RST_MISC;
         fcc_r     <= RST_FCC;
         st_r      <= '0;
         en_r      <= '0;
         irq_r     <= 1'b0;
      end
      else
      begin
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata_r  <= hrdata_nxt;
         volt_r    <= volt_nxt;
         term_r    <= term_nxt;
         irth_r    <= irth_nxt;
         misc_r    <= misc_nxt;
         fcc_r     <= fcc_nxt;
         st_r      <= st_nxt;
         en_r      <= en_nxt;
         irq_r     <= irq_nxt;
      end
   end

   // fault pins come from the charger: two flops before any use
   logic [1:0] chg_s1_r, chg_s2_r, chg_d_r;
   logic       bat_s1_r, bat_s2_r, bat_d_r;
   logic       rch_d_r, rch_cond;

   // events: a new nonzero fault code, a battery fault edge, a recharge
   always_comb
   begin
      rch_cond      = charge_full & (soc_pct < fcc_r);
      ev            = '0;
      ev[IRQ_BAT]   = bat_s2_r & ~bat_d_r & misc_r[MASK_BAT_BIT];
      ev[IRQ_CHG]   = (chg_s2_r != 2'b00) & (chg_s2_r != chg_d_r)
                      & misc_r[MASK_CHG_BIT];
      ev[IRQ_RECHG] = rch_cond & ~rch_d_r;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chg_s1_r <= 2'b00;
         chg_s2_r <= 2'b00;
         chg_d_r  <= 2'b00;
         bat_s1_r <= 1'b0;
         bat_s2_r <= 1'b0;
         bat_d_r  <= 1'b0;
         rch_d_r  <= 1'b0;
      end
      else
      begin
         chg_s1_r <= chg_fault_pin;
         chg_s2_r <= chg_s1_r;
         chg_d_r  <= chg_s2_r;
         bat_s1_r <= battery_fault_flag_pin;
         bat_s2_r <= bat_s1_r;
         bat_d_r  <= bat_s2_r;
         rch_d_r  <= rch_cond;
      end
   end

   // watchdog refresh runs regardless of sleep; the charger must never time out
   logic [CW-1:0] wcnt_r, wcnt_nxt;
   logic          wdt_nxt;
   logic [12:0]   pv_nxt;
   logic [11:0]   pre_nxt;
   logic [4:0]    hrs_nxt;
   logic          upd_nxt, done_nxt;
   logic [12:0]   pv_r;
   logic [11:0]   pre_r;
   logic [4:0]    hrs_r;
   logic [6:0]    irc_r, clp_r, trg_r;
   logic [6:0]    irc_nxt, clp_nxt, trg_nxt;
   logic          upd_r, wdt_r, rch_r, done_r;

   // decoded settings toward the charger side
   always_comb
   begin
      wdt_nxt  = (wcnt_r == CW'(WDT_CYC - 1));
      wcnt_nxt = wdt_nxt ? '0 : wcnt_r + 1'b1;
      pv_nxt   = VOLT_OFFSET_MV
                 + {3'b000, volt_r[7:VCODE_LSB], 4'h0};
      pre_nxt  = volt_r[BATLOW_BIT] ? PRE_HIGH_MV : PRE_LOW_MV;
      case (term_r[TIMER_LSB +: 2])
         2'b00:   hrs_nxt = HRS_0;
         2'b01:   hrs_nxt = HRS_1;
         2'b10:   hrs_nxt = HRS_2;
         default: hrs_nxt = HRS_3;
      endcase
      // ir and thermal settings scale straight from their fields
      irc_nxt  = 7'(irth_r[IRCOMP_LSB +: 3]) * IR_STEP_MOHM;
      clp_nxt  = 7'(irth_r[CLAMP_LSB +: 3]) * CLAMP_STEP_MV;
      trg_nxt  = THERMAL_REG_THRESHOLD_BASE_C
                 + 7'(irth_r[THERMAL_REG_THRESHOLD_LSB +: 2]) * THERMAL_REG_THRESHOLD_STEP_C;
      upd_nxt  = (volt_nxt != volt_r) | (term_nxt != term_r)
                 | (irth_nxt != irth_r) | (misc_nxt != misc_r);
      // compare against the current itself; charger termination stays off
      done_nxt = charging & (avg_current_ma <= TERM_MA);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wcnt_r <= '0;
         wdt_r  <= 1'b0;
         pv_r   <= VOLT_OFFSET_MV;
         pre_r  <= PRE_LOW_MV;
         hrs_r  <= HRS_0;
         irc_r  <= '0;
         clp_r  <= '0;
         trg_r  <= THERMAL_REG_THRESHOLD_BASE_C;
         upd_r  <= 1'b0;
         rch_r  <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         wcnt_r <= wcnt_nxt;
         wdt_r  <= wdt_nxt;
         pv_r   <= pv_nxt;
         pre_r  <= pre_nxt;
         hrs_r  <= hrs_nxt;
         irc_r  <= irc_nxt;
         clp_r  <= clp_nxt;
         trg_r  <= trg_nxt;
         upd_r  <= upd_nxt;
         rch_r  <= ev[IRQ_RECHG];
         done_r <= done_nxt;
      end
   end

   // outputs straight from flops; hreadyout and hresp are tied to constants
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = hrdata_r;
   assign volt_ctrl       = volt_r;
   assign term_ctrl       = term_r;
   assign irth_ctrl       = irth_r;
   assign misc_ctrl       = misc_r;
   assign chg_update      = upd_r;
   assign prog_voltage_mv = pv_r;
   assign pre_exit_mv     = pre_r;
   assign fast_timer_hrs  = hrs_r;
   assign ir_comp_mohm    = irc_r;
   assign ir_clamp_mv     = clp_r;
   assign thermal_reg_threshold_degc       = trg_r;
   assign wdt_refresh     = wdt_r;
   assign recharge_req    = rch_r;
   assign charge_done     = done_r;
   assign irq             = irq_r;

   // helper: cycles since the last watchdog refresh
   logic [CW:0] gap_r;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         gap_r <= '0;
      else
         gap_r <= wdt_r ? '0 : gap_r + 1'b1;
   end

   // one clock domain, so one default clocking serves every check
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_vcode_mirror: assert property ($past(hresetn) |->
      volt_r[7:2] == $past(gauge_vcode)) else $error("vcode not mirrored");
   a_prog_voltage: assert property ($past(hresetn, 2) |->
      pv_r == VOLT_OFFSET_MV + {3'b000, $past(gauge_vcode, 2), 4'h0})
      else $error("programmed voltage wrong");
   a_precharge_sel: assert property (we_volt |-> ##2
      pre_r == ($past(hwdata[BATLOW_BIT], 2) ? PRE_HIGH_MV : PRE_LOW_MV))
      else $error("precharge threshold wrong");
   a_recharge_fixed: assert property (volt_r[0] == 1'b1)
      else $error("recharge select not fixed");
   a_term_off: assert property (term_r[7] == 1'b0)
      else $error("termination enabled");
   a_wdt_interval: assert property (gap_r <= (CW+1)'(WDT_CYC)
      && term_r[5:4] == 2'b01) else $error("watchdog refresh late");
   a_irth_write: assert property (we_irth |=>
      irth_r == $past(hwdata[7:0])) else $error("ir thermal write lost");
   a_misc_reserved: assert property (misc_r[3:2] == 2'b10)
      else $error("reserved bits wrong");
   a_batoff_follow: assert property ($past(hresetn) |->
      misc_r[BATOFF_BIT] == $past(gauge_batfet_off))
      else $error("battery switch bit wrong");
   a_mask_gates: assert property (!misc_r[MASK_BAT_BIT]
      && !st_r[IRQ_BAT] |=> !st_r[IRQ_BAT]) else $error("masked fault set");
   a_temp_zero: assert property (!term_r[0] && !misc_r[4])
      else $error("temperature profile bit set");
   a_ro_write: assert property (we_volt |=>
      volt_r[7:2] == $past(gauge_vcode)) else $error("read-only bits written");
   a_irq_level: assert property (irq == |(st_r & en_r))
      else $error("interrupt level wrong");
   a_timer_code: assert property (term_r[2:1] == 2'b11 |=>
      fast_timer_hrs == HRS_3) else $error("timer hours wrong");
   a_done_level: assert property (charging
      && avg_current_ma <= TERM_MA |=> charge_done)
      else $error("termination not reported");
   a_rechg_pulse: assert property (recharge_req |=>
      !recharge_req) else $error("recharge request too long");
   a_clear_works: assert property (we_clr && hwdata[IRQ_BAT]
      && !ev[IRQ_BAT] |=> !st_r[IRQ_BAT])
      else $error("status clear lost");

   // main scenarios: a write, a fault, a refresh, an interrupt, a recharge
   c_volt_write: cover property (we_volt ##1 chg_update);
   c_chg_fault:  cover property (ev[IRQ_CHG] ##1 st_r[IRQ_CHG]);
   c_wdt_pulse:  cover property (wdt_refresh);
   c_irq_rise:   cover property (!irq ##1 irq);
   c_recharge:   cover property (recharge_req);
endmodule

// [verification/charger_model.sv]
// behavioural model of the external charger on the fault and watchdog pins
`timescale 1ns/1ps
module charger_model
#(
   parameter int WD_LIMIT = 60   // longest refresh gap tolerated, cycles
)
(
   input  wire logic       hclk,           // clock
   input  wire logic       hresetn,        // reset, low
   input  wire logic       wdt_refresh,    // refresh pulse from gauge
   input  wire logic [1:0] fault_code,     // fault code to report
   input  wire logic       battery_fault_flag,      // battery fault to report
   output logic [1:0]      chg_fault_pin,  // fault code pins
   output logic            battery_fault_flag_pin,  // battery fault pin
   output logic            wd_expired      // refresh came too late
);
   int gap;
   // pins follow the commanded faults one edge later, as a charger would
   // a late refresh latches expiry; a real charger would drop its settings
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chg_fault_pin <= 2'h0;
         battery_fault_flag_pin <= 1'b0;
         wd_expired    <= 1'b0;
         gap           <= 0;
      end
      else
      begin
         chg_fault_pin <= fault_code;
         battery_fault_flag_pin <= battery_fault_flag;
         gap           <= wdt_refresh ? 0 : gap + 1;
         if (gap > WD_LIMIT)
            wd_expired <= 1'b1;
      end
   end
endmodule

// [verification/charger_shadow_control_regs_bench.sv]
// self-checking bench for the charger shadow control registers
`timescale 1ns/1ps
module charger_shadow_control_regs_bench;
   import charger_regs_pkg::*;
   localparam int WDT = 50;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, fcode, chg_fault_pin;
   logic [2:0]  hsize;
   logic [5:0]  vcode;
   logic batoff, bfault, battery_fault_flag_pin, charging, charge_full, wd_expired;
   logic [7:0]  soc, volt_ctrl, term_ctrl, irth_ctrl, misc_ctrl;
   logic [15:0] avg_ma;
   logic [12:0] prog_mv;
   logic [11:0] pre_mv;
   logic [4:0]  hrs;
   logic [6:0]  mohm, clamp, degc;
   logic chg_update, wdt_refresh, recharge_req, charge_done, irq;
   int miscompares, checked, n;
   assign hready = hreadyout;

   charger_shadow_control_regs #(.WDT_CYC(WDT)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .gauge_vcode(vcode), .gauge_batfet_off(batoff),
      .chg_fault_pin(chg_fault_pin), .battery_fault_flag_pin(battery_fault_flag_pin),
      .charging(charging), .charge_full(charge_full), .soc_pct(soc),
      .avg_current_ma(avg_ma), .volt_ctrl(volt_ctrl),
      .term_ctrl(term_ctrl), .irth_ctrl(irth_ctrl), .misc_ctrl(misc_ctrl),
      .chg_update(chg_update), .prog_voltage_mv(prog_mv),
      .pre_exit_mv(pre_mv), .fast_timer_hrs(hrs), .ir_comp_mohm(mohm),
      .ir_clamp_mv(clamp), .thermal_reg_threshold_degc(degc), .wdt_refresh(wdt_refresh),
      .recharge_req(recharge_req), .charge_done(charge_done), .irq(irq));

   charger_model #(.WD_LIMIT(WDT + 10)) partner (
      .hclk(hclk), .hresetn(hresetn), .wdt_refresh(wdt_refresh),
      .fault_code(fcode), .battery_fault_flag(bfault),
      .chg_fault_pin(chg_fault_pin), .battery_fault_flag_pin(battery_fault_flag_pin),
      .wd_expired(wd_expired));

   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // verdict; the only place the run ends
   task automatic conclude();
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   // one single ahb-lite transfer; waits on hready, never assumes latency
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsel   <= 1'b1;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic rchk(input string nm, input logic [31:0] a,
                       input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(nm, e, q);
   endtask

   // lets derived outputs and synchronisers settle
   task automatic settle(input int c);
      repeat (c) @(posedge hclk);
   endtask

   // cut a hang short; tests need well under this span
   initial
   begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      conclude();
   end

   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; vcode = 6'h2a;
      batoff = 1'b0; fcode = 2'h0; bfault = 1'b0; charging = 1'b0;
      charge_full = 1'b0; soc = 8'h32; avg_ma = 16'h0400;
      miscompares = 0; checked = 0;
      settle(3);
      hresetn <= 1'b1;
      settle(1);
      // reset contents, gauge-owned voltage code shown
      rchk("volt", 32'h1e4, 32'ha9);
      rchk("term", 32'h1e8, 32'h1a);
      rchk("irth", 32'h1ec, 32'h03);
      rchk("misc", 32'h1f0, 32'h4b);
      rchk("unmapped", 32'h400, 32'h0);
      chk("hresp", 0, hresp);
      // only the precharge exit bit is writable here
      xfer(32'h1e4, 1'b1, 32'h00);
      rchk("volt wr", 32'h1e4, 32'ha9);
      xfer(32'h1e4, 1'b1, 32'hff);
      rchk("volt wr", 32'h1e4, 32'hab);
      settle(3);
      chk("pre_exit", 32'hbb8, pre_mv);
      vcode <= 6'h3f;
      settle(3);
      chk("volt_ctrl", 32'hff, volt_ctrl);
      chk("prog_mv", 32'd4512, prog_mv);
      // fixed bits resist writes; every timer code
      for (int i = 0; i < 4; i++)
      begin
         xfer(32'h1e8, 1'b1, 32'hf9 | (i << 1));
         rchk("term wr", 32'h1e8, 32'h58 | (i << 1));
         settle(3);
         chk("timer", (i == 0) ? 5 : (i == 1) ? 8 : (i == 2) ? 12 : 20,
             hrs);
         chk("term_ctrl", 32'h58 | (i << 1), term_ctrl);
      end
      // every thermal code, resistor and clamp weights
      for (int i = 0; i < 4; i++)
      begin
         xfer(32'h1ec, 1'b1, 32'h49 * i);
         rchk("irth wr", 32'h1ec, 32'h49 * i);
         settle(3);
         chk("ir_mohm", ((8'h49 * i) >> 5) * 10, mohm);
         chk("clamp", (((8'h49 * i) >> 2) & 7) * 16, clamp);
         chk("thermal_reg_threshold", 60 + 20 * i, degc);
         chk("irth_ctrl", 32'h49 * i, irth_ctrl);
      end
      xfer(32'h1f0, 1'b1, 32'hff);
      settle(1);
      chk("update", 1, chg_update);
      rchk("misc wr", 32'h1f0, 32'hcb);
      chk("misc_ctrl", 32'hcb, misc_ctrl);
      xfer(32'h1f0, 1'b1, 32'h03);
      rchk("misc wr", 32'h1f0, 32'h0b);
      batoff <= 1'b1;
      settle(2);
      rchk("batfet", 32'h1f0, 32'h2b);
      // battery fault raises, clear drops the interrupt
      xfer(32'h1cc, 1'b1, 32'h7);
      bfault <= 1'b1;
      settle(8);
      chk("irq bat", 1, irq);
      rchk("status", 32'h1c4, 32'h1);
      xfer(32'h1c8, 1'b1, 32'h1);
      settle(2);
      chk("irq clr", 0, irq);
      // disabled enable keeps irq low though status is set
      xfer(32'h1cc, 1'b1, 32'h0);
      fcode <= 2'h3;
      settle(8);
      rchk("status", 32'h1c4, 32'h2);
      chk("irq off", 0, irq);
      xfer(32'h1cc, 1'b1, 32'h2);
      settle(2);
      chk("irq chg", 1, irq);
      xfer(32'h1c8, 1'b1, 32'h7);
      // battery mask bit cleared: a new fault is not flagged
      bfault <= 1'b0;
      xfer(32'h1f0, 1'b1, 32'h02);
      settle(6);
      bfault <= 1'b1;
      settle(8);
      rchk("masked", 32'h1c4, 32'h0);
      // gauge-driven recharge below the full-charge-clear level
      charge_full <= 1'b1;
      settle(2);
      chk("rechg pulse", 1, recharge_req);
      settle(1);
      chk("rechg end", 0, recharge_req);
      settle(1);
      rchk("rechg", 32'h1c4, 32'h4);
      charging <= 1'b1;
      avg_ma <= 16'h0100;
      settle(3);
      chk("done", 1, charge_done);
      avg_ma <= 16'h0101;
      settle(3);
      chk("not done", 0, charge_done);
      // refresh spacing, counted between two pulses
      n = 0;
      while (wdt_refresh !== 1'b1 && n < 200)
      begin
         @(posedge hclk);
         n++;
      end
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (wdt_refresh !== 1'b1 && n < 200);
      chk("wdt gap", WDT, n);
      chk("wd_expired", 0, wd_expired);
      conclude();
   end
endmodule
